// File: core/dma_channel_event_control.sv
// dma channel event control core: apb registers, arbitration and crc feedback
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module dma_channel_event_control
  import dma_event_pkg::*;
#(
  parameter int NCH = NUM_CH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt request sources, one-cycle pulses
  input wire logic [255:0] irqPulse,
  // transfer engine
  output logic xferStart,
  output logic [CH_W-1:0] xferChan,
  output logic xferActive,
  output logic xferExtAddr,
  output logic xferCrcRoute,
  output logic xferAbort,
  input wire logic blockDone,
  input wire logic patternMatch,
  input wire logic crcBitValid,
  input wire logic crcBit,
  // status
  output logic [NCH-1:0] chanEnable,
  output logic [NCH-1:0] abortFlag,
  output logic [15:0] crcValue
);

  // the channel index and crc select are two bits wide
  generate
    if (NCH < 2 || NCH > 4) begin : gBadCount
      $error("NCH must lie between 2 and 4");
    end
    // guards a package change that shrinks the channel index
    if ((1 << CH_W) < NCH) begin : gBadWidth
      $error("CH_W too narrow to index every channel");
    end
  endgenerate

  chan_if chIf[NCH] ();

  //////////////////////////////////////////////////////////////////////////////
  // apb decode
  // register map, byte addresses:
  //   0x000 crc feedback mask, bit zero held set
  //   0x004 crc control: enable bit 7, channel select bits 1:0
  //   0x008 crc data: a write seeds, a read returns the running value
  //   0x00c abort status: one flag per channel, write one to clear
  //   0x040 + 0x010 * n: channel n control, and its event control at +0x004
  //   channel control: 8 chain direction, 7 enable, 6 allow events, 5 chain,
  //     4 auto enable, 3 extended addressing, 2 event detected, 1:0 priority
  //   event control: 23:16 abort number, 15:8 start number, 7 force, 6 abort,
  //     5 pattern abort, 4 start enable, 3 abort enable
  // any other address answers with pslverr, reads zero and ignores writes

  // access strobes; reads are set up one cycle ahead of their access
  wire wrAcc = psel & penable & pwrite;
  wire rdSetup = psel & ~penable & ~pwrite;
  wire maskSel = paddr == CRC_MASK_OFF;
  wire crcCtrlSel = paddr == CRC_CTRL_OFF;
  wire crcDataSel = paddr == CRC_DATA_OFF;
  wire statSel = paddr == ABORT_STAT_OFF;
  logic [NCH-1:0] chCtrlSel;
  logic [NCH-1:0] chEvSel;
  logic [31:0] chRd [NCH];

  // per-channel address match and read data
  generate
    for (genvar i = 0; i < NCH; i++) begin : gDec
      wire [11:0] chAddr = CH_BASE + CH_STRIDE * 12'(i);
      assign chCtrlSel[i] = paddr == chAddr + CH_CTRL_OFF;
      assign chEvSel[i] = paddr == chAddr + CH_EV_OFF;
      assign chRd[i] = chCtrlSel[i] ? chIf[i].ctrlRd :
        chEvSel[i] ? chIf[i].evRd : 32'h00000000;
    end
  endgenerate

  wire anyChSel = |{chCtrlSel, chEvSel};
  wire mapped = maskSel | crcCtrlSel | crcDataSel | statSel | anyChSel;

  //////////////////////////////////////////////////////////////////////////////
  // global registers

  logic [15:0] mask_q;
  logic crc_enable_q;
  logic [CH_W-1:0] crcSel_q;
  logic [15:0] crc_q, crc_d;

  // mask and crc control writes; bit zero of the mask is held set
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mask_q <= MASK_RESET;
      crc_enable_q <= 1'b0;
      crcSel_q <= '0;
    end else begin
      if (wrAcc & maskSel) begin
        mask_q <= pwdata[15:0] | MASK_RESET;
      end
      if (wrAcc & crcCtrlSel) begin
        crc_enable_q <= pwdata[CRC_EN_BIT];
        crcSel_q <= pwdata[CRC_SEL_LSB +: CH_W];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // arbitration and transfer sequencing

  arb_state_type state_q, state_d;
  logic [CH_W-1:0] active_q, active_d;
  logic [CH_W-1:0] win;
  logic found;
  logic [1:0] bestPri;
  logic [NCH-1:0] req;
  logic [NCH-1:0] abortVec;
  logic [NCH-1:0] extVec;
  logic [1:0] priVec [NCH];
  logic start_q, ext_q, route_q;

  // slice status in plain vectors: an interface array takes constant indices only
  generate
    for (genvar i = 0; i < NCH; i++) begin : gVec
      assign req[i] = chIf[i].request;
      assign priVec[i] = chIf[i].pri;
      assign extVec[i] = chIf[i].extAddr;
      assign abortVec[i] = chIf[i].abortReq;
      assign chanEnable[i] = chIf[i].enable;
      assign abortFlag[i] = chIf[i].abortFlag;
    end
  endgenerate

  // highest priority wins; a later channel needs strictly more to take over
  // no rotation, so a steadily busy high level can starve the lower ones
  always_comb begin
    found = 1'b0;
    win = '0;
    bestPri = 2'h0;
    for (int i = 0; i < NCH; i++) begin
      if (req[i] && (!found || priVec[i] > bestPri)) begin
        found = 1'b1;
        win = CH_W'(i);
        bestPri = priVec[i];
      end
    end
  end

  // sequencer status; done and abort in one cycle simply end the transfer
  wire busy = state_q == ARB_BUSY;
  wire curAbort = busy & |abortVec;
  wire granting = (state_q == ARB_IDLE) & found;

  // one transfer at a time; abort or completion returns to idle
  always_comb begin
    state_d = state_q;
    active_d = active_q;
    case (state_q)
      ARB_IDLE: begin
        if (found) begin
          state_d = ARB_BUSY;
          active_d = win;
        end
      end
      ARB_BUSY: begin
        if (blockDone | curAbort) begin
          state_d = ARB_IDLE;
        end
      end
      default: begin
        state_d = ARB_IDLE;
      end
    endcase
  end

  // sequencer registers and registered engine outputs
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ARB_IDLE;
      active_q <= '0;
      start_q <= 1'b0;
      ext_q <= 1'b0;
      route_q <= 1'b0;
    end else begin
      state_q <= state_d;
      active_q <= active_d;
      start_q <= granting;
      if (granting) begin
        ext_q <= extVec[win];
        route_q <= crc_enable_q & (crcSel_q == win);
      end
    end
  end

  assign xferStart = start_q;
  assign xferChan = active_q;
  assign xferActive = busy;
  assign xferExtAddr = ext_q;
  assign xferCrcRoute = route_q;
  assign xferAbort = curAbort;

  //////////////////////////////////////////////////////////////////////////////
  // channel slices and their event wiring

  // completion goes to both neighbours; each slice picks by its direction bit
  logic [NCH-1:0] doneVec;

  generate
    for (genvar i = 0; i < NCH; i++) begin : gCh
      wire isActive = busy & (active_q == CH_W'(i));
      assign doneVec[i] = isActive & blockDone;
      assign chIf[i].ctrlWr = wrAcc & chCtrlSel[i];
      assign chIf[i].evWr = wrAcc & chEvSel[i];
      assign chIf[i].wdata = pwdata;
      assign chIf[i].startHit = irqPulse[chIf[i].startNum];
      assign chIf[i].abortHit = irqPulse[chIf[i].abortNum];
      assign chIf[i].patternHit = isActive & patternMatch;
      assign chIf[i].grant = granting & (win == CH_W'(i));
      assign chIf[i].done = doneVec[i];
      assign chIf[i].flagClr = wrAcc & statSel & pwdata[i];
      // natural order: lower index is the higher-priority neighbour
      if (i == 0) begin : gFirst
        assign chIf[i].doneHigher = 1'b0;
      end else begin : gMid
        assign chIf[i].doneHigher = doneVec[i-1];
      end
      if (i == NCH - 1) begin : gLast
        assign chIf[i].doneLower = 1'b0;
      end else begin : gTop
        assign chIf[i].doneLower = doneVec[i+1];
      end
      dma_channel_slice uSlice (
        .clk(clk),
        .rstn(rstn),
        .ch(chIf[i])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // crc shift register, one serial bit per cycle from the routed channel

  wire crcShift = crcBitValid & busy & crc_enable_q & (crcSel_q == active_q);
  wire feedback = crc_q[15] ^ crcBit;

  // galois form: masked stages take the feedback term
  // length fixed at sixteen stages; shorter codes need software alignment
  always_comb begin
    crc_d = crc_q;
    if (wrAcc & crcDataSel) begin
      crc_d = pwdata[15:0];
    end else if (crcShift) begin
      crc_d[0] = feedback & mask_q[0];
      for (int k = 1; k < 16; k++) begin
        crc_d[k] = crc_q[k-1] ^ (mask_q[k] & feedback);
      end
    end
  end

  // software seed write takes precedence over a shift in the same cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      crc_q <= CRC_SEED_RESET;
    end else begin
      crc_q <= crc_d;
    end
  end

  assign crcValue = crc_q;

  //////////////////////////////////////////////////////////////////////////////
  // apb read mux and answer

  logic [31:0] chRdAll;

  always_comb begin
    chRdAll = 32'h00000000;
    for (int i = 0; i < NCH; i++) begin
      chRdAll = chRdAll | chRd[i];
    end
  end

  wire [31:0] globRd = maskSel ? {16'h0000, mask_q} :
    crcCtrlSel ? {24'h000000, crc_enable_q, 5'h00, crcSel_q} :
    crcDataSel ? {16'h0000, crc_q} :
    statSel ? {{(32-NCH){1'b0}}, abortFlag} : 32'h00000000;

  wire [31:0] readWord = mapped ? (globRd | chRdAll) : 32'h00000000;
  logic [31:0] rdData_q;

  // read word captured at the end of setup so prdata leaves a flip-flop;
  // the price is that a register moving in the access cycle reads one cycle old
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdData_q <= 32'h00000000;
    end else if (!penable) begin
      rdData_q <= rdSetup ? readWord : 32'h00000000;
    end
  end

  // zero wait state; unmapped addresses answer with an error and zero data
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = rdData_q;

endmodule

// File: core/dma_event_pkg.sv
// constants, offsets and types shared by the dma channel event control block
package dma_event_pkg;

  // channel count and index width
  localparam int NUM_CH = 4;
  localparam int CH_W = 2;

  // register byte offsets on the apb side
  localparam logic [11:0] CRC_MASK_OFF = 12'h000;
  localparam logic [11:0] CRC_CTRL_OFF = 12'h004;
  localparam logic [11:0] CRC_DATA_OFF = 12'h008;
  localparam logic [11:0] ABORT_STAT_OFF = 12'h00c;
  localparam logic [11:0] CH_BASE = 12'h040;
  localparam logic [11:0] CH_STRIDE = 12'h010;
  localparam logic [11:0] CH_CTRL_OFF = 12'h000;
  localparam logic [11:0] CH_EV_OFF = 12'h004;

  // channel_control fields
  localparam int CTL_PRI_LSB = 0;
  localparam int CTL_EDET_BIT = 2;
  localparam int CTL_EXT_BIT = 3;
  localparam int CTL_AUTO_BIT = 4;
  localparam int CTL_CHAIN_BIT = 5;
  localparam int CTL_ALLOW_BIT = 6;
  localparam int CTL_EN_BIT = 7;
  localparam int CTL_DIR_BIT = 8;

  // channel_event_control fields
  localparam int EV_ABORT_TRIGGER_ENABLE_BIT = 3;
  localparam int EV_START_TRIGGER_ENABLE_BIT = 4;
  localparam int EV_PATTERN_ABORT_ENABLE_BIT = 5;
  localparam int EV_ABORT_BIT = 6;
  localparam int EV_FORCE_BIT = 7;
  localparam int EV_START_LSB = 8;
  localparam int EV_ABTNUM_LSB = 16;

  // crc control fields
  localparam int CRC_SEL_LSB = 0;
  localparam int CRC_EN_BIT = 7;

  // values after reset
  localparam logic [7:0] TRIG_RESET = 8'hff;
  localparam logic [15:0] MASK_RESET = 16'h0001;
  localparam logic [15:0] CRC_SEED_RESET = 16'h0000;

  // transfer sequencer states
  typedef enum logic [0:0] {
    ARB_IDLE = 1'b0,
    ARB_BUSY = 1'b1
  } arb_state_type;

endpackage

// File: core/chan_if.sv
// signals between the core and one channel slice
`timescale 1ns/1ps
interface chan_if;
  logic ctrlWr;
  logic evWr;
  logic [31:0] wdata;
  logic startHit;
  logic abortHit;
  logic patternHit;
  logic doneHigher;
  logic doneLower;
  logic grant;
  logic done;
  logic flagClr;
  logic [31:0] ctrlRd;
  logic [31:0] evRd;
  logic request;
  logic enable;
  logic extAddr;
  logic abortReq;
  logic abortFlag;
  logic [1:0] pri;
  logic [7:0] startNum;
  logic [7:0] abortNum;

  modport core (output ctrlWr, evWr, wdata, startHit, abortHit, patternHit, doneHigher,
    doneLower, grant, done, flagClr, input ctrlRd, evRd, request, enable, extAddr,
    abortReq, abortFlag, pri, startNum, abortNum);
  modport slice (input ctrlWr, evWr, wdata, startHit, abortHit, patternHit, doneHigher,
    doneLower, grant, done, flagClr, output ctrlRd, evRd, request, enable, extAddr,
    abortReq, abortFlag, pri, startNum, abortNum);
endinterface

// File: core/dma_channel_slice.sv
// per-channel control and event state of the dma block
`timescale 1ns/1ps
module dma_channel_slice
  import dma_event_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // link to the core
  chan_if.slice ch
);

  logic enable_q, enable_d, allow_q, chain_q, dir_q, auto_q, ext_q;
  logic edet_q, edet_d, busy_q, busy_d, flag_q, flag_d;
  logic pattern_abort_enable_q, start_trigger_enable_q, abort_trigger_enable_q;
  logic [1:0] pri_q;
  logic [7:0] startNum_q, abortNum_q;

  // event qualification
  wire accept = enable_q | allow_q;
  wire chainSet = chain_q & (dir_q ? ch.doneLower : ch.doneHigher);
  wire forceEv = ch.evWr & ch.wdata[EV_FORCE_BIT];
  wire irqStart = start_trigger_enable_q & ch.startHit;
  wire startEv = accept & (forceEv | irqStart);
  wire irqAbort = accept & abort_trigger_enable_q & ch.abortHit;
  wire swAbort = accept & ch.evWr & ch.wdata[EV_ABORT_BIT];
  wire patAbort = pattern_abort_enable_q & ch.patternHit;
  wire abortAny = irqAbort | swAbort | patAbort;

  // next state: set beats clear on every hardware flag
  always_comb begin
    enable_d = ch.ctrlWr ? ch.wdata[CTL_EN_BIT] : enable_q;
    if ((ch.done & ~auto_q) | patAbort) begin
      enable_d = 1'b0;
    end
    if (chainSet) begin
      enable_d = 1'b1;
    end
    edet_d = edet_q;
    if (ch.grant | abortAny) begin
      edet_d = 1'b0;
    end
    if (startEv) begin
      edet_d = 1'b1;
    end
    busy_d = busy_q;
    if (ch.done | abortAny) begin
      busy_d = 1'b0;
    end
    if (ch.grant) begin
      busy_d = 1'b1;
    end
    flag_d = ch.flagClr ? 1'b0 : flag_q;
    if (irqAbort) begin
      flag_d = 1'b1;
    end
  end

  // state registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {enable_q, allow_q, chain_q, dir_q, auto_q, ext_q} <= 6'h00;
      {edet_q, busy_q, flag_q, pattern_abort_enable_q, start_trigger_enable_q, abort_trigger_enable_q} <= 6'h00;
      pri_q <= 2'h0;
      startNum_q <= TRIG_RESET;
      abortNum_q <= TRIG_RESET;
    end else begin
      enable_q <= enable_d;
      edet_q <= edet_d;
      busy_q <= busy_d;
      flag_q <= flag_d;
      if (ch.ctrlWr) begin
        allow_q <= ch.wdata[CTL_ALLOW_BIT];
        chain_q <= ch.wdata[CTL_CHAIN_BIT];
        dir_q <= ch.wdata[CTL_DIR_BIT];
        auto_q <= ch.wdata[CTL_AUTO_BIT];
        ext_q <= ch.wdata[CTL_EXT_BIT];
        pri_q <= ch.wdata[CTL_PRI_LSB +: 2];
      end
      if (ch.evWr) begin
        startNum_q <= ch.wdata[EV_START_LSB +: 8];
        abortNum_q <= ch.wdata[EV_ABTNUM_LSB +: 8];
        pattern_abort_enable_q <= ch.wdata[EV_PATTERN_ABORT_ENABLE_BIT];
        start_trigger_enable_q <= ch.wdata[EV_START_TRIGGER_ENABLE_BIT];
        abort_trigger_enable_q <= ch.wdata[EV_ABORT_TRIGGER_ENABLE_BIT];
      end
    end
  end

  // outputs; force and abort bits always read zero
  assign ch.request = enable_q & edet_q & ~busy_q;
  assign ch.enable = enable_q;
  assign ch.extAddr = ext_q;
  assign ch.abortReq = abortAny & busy_q;
  assign ch.abortFlag = flag_q;
  assign ch.pri = pri_q;
  assign ch.startNum = startNum_q;
  assign ch.abortNum = abortNum_q;
  assign ch.ctrlRd = {23'h000000, dir_q, enable_q, allow_q, chain_q, auto_q, ext_q,
    edet_q, pri_q};
  assign ch.evRd = {8'h00, abortNum_q, startNum_q, 2'h0, pattern_abort_enable_q, start_trigger_enable_q, abort_trigger_enable_q,
    3'h0};

endmodule

// File: tb/dma_channel_event_control_asserts.sv
// port assertions for the dma channel event control block
`timescale 1ns/1ps
module dma_channel_event_control_asserts
  import dma_event_pkg::*;
#(
  parameter int NCH = NUM_CH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // transfer and crc
  input wire logic xferStart,
  input wire logic [CH_W-1:0] xferChan,
  input wire logic xferActive,
  input wire logic xferAbort,
  input wire logic crcBit,
  input wire logic [NCH-1:0] chanEnable,
  input wire logic [15:0] crcValue
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // mask shadow, so each crc step is predicted from the ports alone
  logic [15:0] mask_q;
  logic [15:0] stepVal;
  wire acc = psel && penable;
  wire rdAcc = acc && !pwrite;
  wire seedWr = acc && pwrite && paddr == CRC_DATA_OFF;
  wire fb = crcValue[15] ^ crcBit;
  assign stepVal = {crcValue[14:0], 1'b0} ^ ({16{fb}} & mask_q);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) mask_q <= MASK_RESET;
    else if (acc && pwrite && paddr == CRC_MASK_OFF) mask_q <= pwdata[15:0] | 16'h0001;
  end
  mask_lsb_a: assert property (rdAcc && paddr == CRC_MASK_OFF |-> prdata[0])
    else $error("mask bit zero read low");
  strobe_zero_a: assert property (rdAcc && paddr >= CH_BASE && paddr[3:0] == 4'h4
    |-> prdata[7:6] == 2'b00) else $error("strobe bits read high");
  start_enabled_a: assert property (xferStart
    |-> |($past(chanEnable) & (NCH'(1) << xferChan))) else $error("start on disabled channel");
  start_pulse_a: assert property (xferStart |-> xferActive ##1 !xferStart)
    else $error("start pulse malformed");
  abort_ends_a: assert property (xferAbort |-> xferActive ##1 !xferActive)
    else $error("abort did not end transfer");
  crc_step_a: assert property (crcValue != $past(crcValue) && !$past(seedWr)
    |-> crcValue == $past(stepVal)) else $error("crc step wrong");
  bad_addr_a: assert property (acc && paddr == 12'h010 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  chan_hold_a: assert property (xferActive && $past(xferActive) |-> $stable(xferChan))
    else $error("channel changed mid transfer");
  c_start: cover property (xferStart);
  c_abort: cover property (xferAbort);
  c_crc: cover property (crcValue != $past(crcValue));
endmodule

bind dma_channel_event_control dma_channel_event_control_asserts #(.NCH(NCH)) chk_i (
  .clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pslverr,
  .xferStart, .xferChan, .xferActive, .xferAbort, .crcBit, .chanEnable, .crcValue
);

// File: tb/dma_far_end.sv
// behavioural far end: ends each transfer that is not aborted with a block completion pulse, unless lat is zero
`timescale 1ns/1ps
module dma_far_end (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // transfer engine view
  input wire logic xferActive,
  input wire logic xferAbort,
  input wire logic [7:0] lat,
  output logic blockDone
);
  // lat of zero never completes, so aborts can be tried on a live transfer
  logic [7:0] cnt_q;
  wire live = xferActive && !xferAbort && !blockDone;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 8'h00;
      blockDone <= 1'b0;
    end else begin
      cnt_q <= live ? cnt_q + 8'h01 : 8'h00;
      blockDone <= live && lat != 8'h00 && cnt_q + 8'h01 == lat;
    end
  end
endmodule

// File: tb/dma_channel_event_control_test.sv
// self-checking bench for the dma channel event control block
`timescale 1ns/1ps
module dma_channel_event_control_test
  import dma_event_pkg::*;
;
  typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] e;} row_type;
  // stimulus, all given a value at time zero
  logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic patternMatch = 1'b0, crcBitValid = 1'b0, crcBit = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [255:0] irqPulse = '0;
  logic [7:0] lat = 8'h03;
  logic [31:0] prdata;
  logic pready, pslverr, xferStart, xferActive, xferExtAddr, xferCrcRoute, xferAbort;
  logic blockDone, lastErr;
  logic [CH_W-1:0] xferChan;
  logic [NUM_CH-1:0] chanEnable, abortFlag;
  logic [15:0] crcValue;
  int nErrors = 0;
  int checkCount = 0;
  // address, value written, value expected back
  row_type rows[5] = '{
    '{CRC_MASK_OFF, 32'h0000_8004, 32'h0000_8005},
    '{CRC_MASK_OFF, 32'hffff_0000, 32'h0000_0001},
    '{CH_BASE + CH_EV_OFF, 32'h00ab_cd78, 32'h00ab_cd38},
    '{CH_BASE + CH_STRIDE * 12'h3, 32'h0000_01ff, 32'h0000_01fb},
    '{CH_BASE + CH_EV_OFF, 32'h00ff_ff00, 32'h00ff_ff00}
  };
  always #50 clk = ~clk;
  dma_channel_event_control dut (
    .clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .irqPulse, .xferStart, .xferChan, .xferActive, .xferExtAddr, .xferCrcRoute,
    .xferAbort, .blockDone, .patternMatch, .crcBitValid, .crcBit, .chanEnable,
    .abortFlag, .crcValue
  );
  dma_far_end far (.clk, .rstn, .xferActive, .xferAbort, .lat, .blockDone);
  ////////////////////////////////////////////////////////////
  function automatic logic [11:0] cc(input int i);
    return CH_BASE + CH_STRIDE * 12'(i);
  endfunction
  function automatic logic [11:0] ec(input int i);
    return cc(i) + CH_EV_OFF;
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checkCount++;
    if (s !== e) begin
      nErrors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  // one apb transfer; always opens on a fresh edge so strobes never collide
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rd(input string n, input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(n, e, r);
  endtask
  task automatic ws(input int c);
    @(posedge clk); // a pulse seen by the previous call still stands at its edge
    for (int k = 0; k < 30 && xferStart !== 1'b1; k++) @(posedge clk);
    chk("xferStart", 32'h1, 32'(xferStart));
    chk("xferChan", c, 32'(xferChan));
  endtask
  task automatic wi();
    for (int k = 0; k < 40 && xferActive !== 1'b0; k++) @(posedge clk);
    chk("xferActive", 32'h0, 32'(xferActive));
  endtask
  task automatic irq(input logic [255:0] v);
    @(posedge clk);
    irqPulse <= v;
    @(posedge clk);
    irqPulse <= '0;
  endtask
  task automatic go(input int i, input logic [31:0] c, input logic [31:0] e);
    wr(cc(i), c);
    wr(ec(i), e);
    ws(i);
  endtask
  task automatic printVerdict();
    if (nErrors == 0 && checkCount > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    logic [15:0] m;
    logic fb;
    logic [7:0] pat;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd("row", rows[i].a, rows[i].e);
    end
    // reset in mid run, then reset values and a refused address
    @(posedge clk);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    rd("evReset", ec(3), 32'h00ff_ff00);
    rd("maskReset", CRC_MASK_OFF, 32'h1);
    rd("ctlReset", cc(3), 32'h0);
    rd("unmapped", 12'h010, 32'h0);
    chk("pslverr", 32'h1, 32'(lastErr));
    chk("pready", 32'h1, 32'(pready));
    // two starts at once: priority three first, auto enable kept only on ch0
    wr(cc(0), 32'h91);
    wr(cc(2), 32'h83);
    wr(ec(0), 32'h0a10);
    wr(ec(2), 32'h1410);
    irq((256'h1 << 10) | (256'h1 << 20));
    ws(2);
    ws(0);
    wi();
    chk("en2", 32'h0, 32'(chanEnable[2]));
    chk("en0", 32'h1, 32'(chanEnable[0]));
    // equal priority: the lower channel number is served first
    wr(cc(1), 32'h81);
    wr(ec(1), 32'h1e10);
    irq((256'h1 << 10) | (256'h1 << 30));
    ws(0);
    ws(1);
    wi();
    wr(cc(1), 32'h0);
    // disabled channel keeps events only with the allow bit
    wr(ec(1), 32'h1e10);
    irq(256'h1 << 30);
    rd("ignored", cc(1), 32'h0);
    wr(cc(1), 32'h40);
    irq(256'h1 << 30);
    rd("held", cc(1), 32'h44);
    chk("idle", 32'h0, 32'(xferActive));
    wr(cc(1), 32'hc0);
    ws(1);
    wi();
    // chaining from the lower neighbour only, none from the higher, then direction alone
    wr(cc(1), 32'h120);
    wr(ec(0), 32'h80);
    ws(0);
    wi();
    chk("noChainUp", 32'h0, 32'(chanEnable[1]));
    go(2, 32'h80, 32'h80);
    wi();
    chk("chainDown", 32'h1, 32'(chanEnable[1]));
    wr(cc(1), 32'h100);
    go(2, 32'h80, 32'h80);
    wi();
    chk("noChain", 32'h0, 32'(chanEnable[1]));
    // far end stalls: crc shifting, then the three kinds of abort
    lat <= 8'h00;
    wr(CRC_MASK_OFF, 32'h8005);
    wr(CRC_CTRL_OFF, 32'h83);
    go(3, 32'h98, 32'h0028_0088);
    chk("extAddr", 32'h1, 32'(xferExtAddr));
    chk("crcRoute", 32'h1, 32'(xferCrcRoute));
    wr(CRC_DATA_OFF, 32'h00ff);
    m = 16'h00ff;
    pat = 8'hb4;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      crcBitValid <= 1'b1;
      crcBit <= pat[i];
      fb = m[15] ^ pat[i];
      m = {m[14:0], 1'b0} ^ ({16{fb}} & 16'h8005);
    end
    @(posedge clk);
    crcBitValid <= 1'b0;
    rd("crcValue", CRC_DATA_OFF, 32'(m));
    chk("crcPort", 32'(m), 32'(crcValue));
    irq(256'h1 << 40);
    @(posedge clk);
    chk("abortFlag", 32'h1, 32'(abortFlag[3]));
    chk("irqAbort", 32'h0, 32'(xferActive));
    wr(ABORT_STAT_OFF, 32'h8);
    go(3, 32'h98, 32'h0028_0088);
    wr(ec(3), 32'h0028_0048);
    @(posedge clk);
    chk("swAbort", 32'h0, 32'(xferActive));
    chk("noFlag", 32'h0, 32'(abortFlag[3]));
    go(3, 32'h98, 32'h00a0);
    @(posedge clk);
    patternMatch <= 1'b1;
    @(posedge clk);
    chk("xferAbort", 32'h1, 32'(xferAbort));
    patternMatch <= 1'b0;
    @(posedge clk);
    chk("pattern_abort_enable", 32'h0, 32'(chanEnable[3]));
    chk("patStop", 32'h0, 32'(xferActive));
    printVerdict();
  end
  // hang guard, far beyond the few hundred cycles the sequence needs
  initial begin
    #2_000_000;
    nErrors++;
    printVerdict();
  end
endmodule
